// ### hw/acc_top.sv
// calibration run control, mode, core select and averaging registers
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_top
  import acc_pkg::*;
#(
  parameter int FG_CYCLES = `ACC_FG_BASE,
  parameter int BG_PHASE  = `ACC_BG_PHASE
) (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_B,
  // register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // calibration engine controls
  output logic            CAL_RESET_B,
  output logic            DIV_RESET_B,
  output logic            FG_RUN,
  output logic            FG_OFFSET_TRIM,
  output logic            BG_RUN,
  output logic            BG_OFFSET_TRIM,
  output logic      [1:0] IDLE_CORE,
  output logic      [2:0] OFFSET_AVERAGING_DEPTH,
  output logic      [2:0] LINEARITY_AVERAGING_DEPTH,
  output logic            SERIAL_LINK_ENABLE,
  // background halt request and interrupt
  input  wire logic       BG_HALT_REQ,
  output logic            IRQ
);
  // refuse counts whose longest run overflows the 16-bit foreground timer
  if (FG_CYCLES < 1 || FG_CYCLES > 512 || BG_PHASE < 1 ||
      BG_PHASE > 65535) begin : g_bad_counts
    $error("acc_top: cycle counts out of range");
  end

  logic       rst_m_r, rst_s_r;
  logic       run_r;
  logic [3:0] mode_r;
  logic [1:0] core_r;
  logic [2:0] offset_averaging_depth_r, lin_avg_r;
  logic [3:0] act_mode_r;
  logic [1:0] act_core_r;
  logic [2:0] act_os_r, act_lin_r;
  logic       run_d_r, link_r;
  logic       foreground_complete_r, halted_r;
  logic [1:0] irq_st_r, irq_msk_r;
  logic [15:0] cnt_r;
  logic       halt_1_r, halt_2_r, halt_3_r, halt_r;
  acc_state_t st_r, st_nxt;
  logic       wr_run, wr_mode, wr_core, wr_avg, start;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  assign wr_run  = WR && hit(ADDR, `ACC_OFF_RUN);
  assign wr_mode = WR && hit(ADDR, `ACC_OFF_MODE);
  assign wr_core = WR && hit(ADDR, `ACC_OFF_CORE);
  assign wr_avg  = WR && hit(ADDR, `ACC_OFF_AVG);
  assign start   = run_r && !run_d_r; // rising edge of run bit

  // software registers
  always_ff @(posedge CLK or negedge rst_s_r) begin
    if (!rst_s_r) begin
      run_r     <= 1'(`ACC_RST_RUN);
      mode_r    <= 4'(`ACC_RST_MODE);
      core_r    <= 2'(`ACC_RST_CORE);
      offset_averaging_depth_r  <= 3'(`ACC_RST_AVG >> 4);
      lin_avg_r <= 3'(`ACC_RST_AVG);
      link_r    <= 1'b0;
      irq_msk_r <= 2'h0;
    end else begin
      if (wr_run) run_r <= WDATA[0];
      if (wr_mode) mode_r <= WDATA[3:0];
      if (wr_core) core_r <= WDATA[1:0];
      if (wr_avg) begin
        offset_averaging_depth_r  <= WDATA[6:4];
        lin_avg_r <= WDATA[2:0];
      end
      if (WR && hit(ADDR, `ACC_OFF_LINK)) link_r <= WDATA[0];
      if (WR && hit(ADDR, `ACC_OFF_IRQ_MSK)) irq_msk_r <= WDATA[1:0];
    end
  end

  // settings latched at each calibration start
  always_ff @(posedge CLK or negedge rst_s_r) begin
    if (!rst_s_r) begin
      run_d_r    <= 1'b0;
      act_mode_r <= 4'(`ACC_RST_MODE);
      act_core_r <= 2'(`ACC_RST_CORE);
      act_os_r   <= 3'(`ACC_RST_AVG >> 4);
      act_lin_r  <= 3'(`ACC_RST_AVG);
    end else begin
      run_d_r <= run_r;
      if (start) begin
        act_mode_r <= mode_r;
        act_core_r <= core_r;
        act_os_r   <= offset_averaging_depth_r;
        act_lin_r  <= lin_avg_r;
      end
    end
  end

  // background halt request from the engine side, three-stage sampled
  always_ff @(posedge CLK or negedge rst_s_r) begin
    if (!rst_s_r) begin
      halt_1_r <= 1'b0;
      halt_2_r <= 1'b0;
      halt_3_r <= 1'b0;
      halt_r   <= 1'b0;
    end else begin
      halt_1_r <= BG_HALT_REQ;
      halt_2_r <= halt_1_r;
      halt_3_r <= halt_2_r;
      if (halt_2_r == halt_3_r) halt_r <= halt_3_r;
    end
  end

  // sequencer next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ACC_HOLD:  if (run_r) st_nxt = ACC_START;
      ACC_START: st_nxt = act_mode_r[`ACC_BIT_FG] ? ACC_FG : ACC_DONE;
      ACC_FG:    if (cnt_r == 16'd0) st_nxt = ACC_DONE;
      ACC_DONE:  st_nxt = act_mode_r[`ACC_BIT_BG] ? ACC_BG : ACC_DONE;
      ACC_BG:    st_nxt = ACC_BG;
      default:   st_nxt = ACC_HOLD;
    endcase
    if (!run_r) st_nxt = ACC_HOLD;
  end

  // sequencer state, foreground timer and status flags
  always_ff @(posedge CLK or negedge rst_s_r) begin
    if (!rst_s_r) begin
      st_r      <= ACC_HOLD;
      cnt_r     <= 16'd0;
      foreground_complete_r <= 1'b0;
      halted_r  <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt == ACC_FG && st_r != ACC_FG)
        cnt_r <= 16'((FG_CYCLES << act_lin_r) - 1);
      else if (cnt_r != 16'd0)
        cnt_r <= cnt_r - 16'd1;
      foreground_complete_r <= (st_nxt == ACC_DONE) || (st_nxt == ACC_BG);
      // halted follows request in background, or done without it
      halted_r <= (st_nxt == ACC_BG) ? halt_r :
                  (st_nxt == ACC_DONE) && !act_mode_r[`ACC_BIT_BG];
    end
  end

  // interrupt status: set wins over write-one clear
  always_ff @(posedge CLK or negedge rst_s_r) begin
    if (!rst_s_r) begin
      irq_st_r <= 2'h0;
    end else begin
      irq_st_r <= (irq_st_r &
                   ~((WR && hit(ADDR, `ACC_OFF_IRQ_ST)) ?
                     WDATA[1:0] : 2'h0)) |
                  {(st_nxt == ACC_BG) && halt_r && !halted_r,
                   (st_nxt inside {ACC_DONE, ACC_BG}) && !foreground_complete_r};
    end
  end

  // registered outputs
  always_ff @(posedge CLK or negedge rst_s_r) begin
    if (!rst_s_r) begin
      CAL_RESET_B               <= 1'b0;
      DIV_RESET_B               <= 1'b0;
      FG_RUN                    <= 1'b0;
      FG_OFFSET_TRIM            <= 1'b0;
      BG_RUN                    <= 1'b0;
      BG_OFFSET_TRIM            <= 1'b0;
      IDLE_CORE                 <= 2'(`ACC_RST_CORE);
      OFFSET_AVERAGING_DEPTH    <= 3'(`ACC_RST_AVG >> 4);
      LINEARITY_AVERAGING_DEPTH <= 3'(`ACC_RST_AVG);
      SERIAL_LINK_ENABLE        <= 1'b0;
      IRQ                       <= 1'b0;
      RDATA                     <= 8'h00;
    end else begin
      CAL_RESET_B    <= run_r;
      DIV_RESET_B    <= run_r;
      FG_RUN         <= (st_nxt == ACC_FG);
      FG_OFFSET_TRIM <= (st_nxt == ACC_FG) &&
                        act_mode_r[`ACC_BIT_OS];
      BG_RUN         <= (st_nxt == ACC_BG) && !halt_r;
      BG_OFFSET_TRIM <= (st_nxt == ACC_BG) && !halt_r &&
                        act_mode_r[`ACC_BIT_BGOS];
      IDLE_CORE      <= act_core_r;
      OFFSET_AVERAGING_DEPTH    <= act_os_r;
      LINEARITY_AVERAGING_DEPTH <= act_lin_r;
      SERIAL_LINK_ENABLE <= link_r && run_r;
      IRQ <= |(irq_st_r & ~irq_msk_r); // a set mask bit blocks
      RDATA <= 8'h00;
      if (RD) begin
        unique case (ADDR)
          `ACC_OFF_RUN:     RDATA <= {7'h00, run_r};
          `ACC_OFF_MODE:    RDATA <= {4'h0, mode_r};
          `ACC_OFF_CORE:    RDATA <= {6'h00, core_r};
          `ACC_OFF_AVG:     RDATA <= {1'b0, offset_averaging_depth_r, 1'b0, lin_avg_r};
          `ACC_OFF_STATUS:  RDATA <= {6'h00, halted_r, foreground_complete_r};
          `ACC_OFF_LINK:    RDATA <= {7'h00, link_r};
          `ACC_OFF_IRQ_ST:  RDATA <= {6'h00, irq_st_r};
          `ACC_OFF_IRQ_MSK: RDATA <= {6'h00, irq_msk_r};
          default:          RDATA <= 8'h00;
        endcase
      end
    end
  end

  // dividers and engine follow the run bit one cycle later
  a_div_reset: assert property (@(posedge CLK)
    disable iff (!rst_s_r)
    $fell(run_r) |=> !DIV_RESET_B && !CAL_RESET_B)
    else $error("dividers not reset after run bit cleared");

  // run bit rising with foreground skipped, or with foreground selected
  sequence s_start_skip;
    $rose(run_r) ##1 (st_r == ACC_START && !act_mode_r[`ACC_BIT_FG]);
  endsequence
  sequence s_start_fg;
    $rose(run_r) ##1 (st_r == ACC_START && act_mode_r[`ACC_BIT_FG]);
  endsequence

  // foreground skipped goes straight to done
  a_fg_skip: assert property (@(posedge CLK)
    disable iff (!rst_s_r)
    s_start_skip ##0 run_r |=> ##1 foreground_complete_r)
    else $error("skip did not report foreground done");

  // foreground selected starts the foreground run before done
  a_fg_start: assert property (@(posedge CLK)
    disable iff (!rst_s_r)
    s_start_fg ##0 run_r |=> FG_RUN && !foreground_complete_r)
    else $error("foreground run did not start");

  // link stays off while calibration is held
  a_link_gate: assert property (@(posedge CLK)
    disable iff (!rst_s_r)
    SERIAL_LINK_ENABLE |-> $past(run_r))
    else $error("link enabled while calibration held");

  // offset trims only ride on their own calibration kind
  a_bgos_gate: assert property (@(posedge CLK)
    disable iff (!rst_s_r)
    BG_OFFSET_TRIM |-> BG_RUN)
    else $error("background offset trim without background");

  a_os_gate: assert property (@(posedge CLK)
    disable iff (!rst_s_r)
    FG_OFFSET_TRIM |-> FG_RUN)
    else $error("foreground offset trim without foreground");

  // latched settings move only at a calibration start
  a_settings_hold: assert property (@(posedge CLK)
    disable iff (!rst_s_r)
    !start |=> $stable(act_os_r) && $stable(act_lin_r))
    else $error("averaging changed outside calibration start");

  a_mode_hold: assert property (@(posedge CLK)
    disable iff (!rst_s_r)
    !start |=> $stable(act_mode_r) && $stable(act_core_r))
    else $error("mode or core changed outside calibration start");

  // run bit clear holds the sequencer idle
  a_hold_state: assert property (@(posedge CLK)
    disable iff (!rst_s_r)
    !run_r |=> st_r == ACC_HOLD && !FG_RUN)
    else $error("engine not held while run bit clear");

  // halted flag and background run never stand together
  a_halt_flag: assert property (@(posedge CLK)
    disable iff (!rst_s_r)
    (st_r == ACC_BG && BG_RUN) |-> !halted_r)
    else $error("halted flag set while background runs");

  // halt request counts only once two samples agree
  a_halt_filter: assert property (@(posedge CLK)
    disable iff (!rst_s_r)
    $rose(halt_r) |-> $past(halt_2_r) && $past(halt_3_r))
    else $error("halt request taken before samples agreed");

  // foreground done event sets its sticky bit even against a clear
  a_fg_event: assert property (@(posedge CLK)
    disable iff (!rst_s_r)
    (st_nxt inside {ACC_DONE, ACC_BG}) && !foreground_complete_r |=> irq_st_r[0])
    else $error("foreground done event lost");

  // interrupt level follows unmasked status one cycle later
  a_irq_level: assert property (@(posedge CLK)
    disable iff (!rst_s_r)
    IRQ == $past(|(irq_st_r & ~irq_msk_r)))
    else $error("interrupt level does not follow unmasked status");
endmodule

// ### hw/acc_consts.svh
// register offsets, field positions, reset values and timing counts
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
`define ACC_OFF_RUN     8'h61
`define ACC_OFF_MODE    8'h62
`define ACC_OFF_CORE    8'h64
`define ACC_OFF_AVG     8'h68
`define ACC_OFF_STATUS  8'h6A
`define ACC_OFF_LINK    8'h70
`define ACC_OFF_IRQ_ST  8'h71
`define ACC_OFF_IRQ_MSK 8'h72
`define ACC_RST_RUN     8'h01
`define ACC_RST_MODE    8'h01
`define ACC_RST_CORE    8'h02
`define ACC_RST_AVG     8'h61
`define ACC_BIT_BGOS    3
`define ACC_BIT_OS      2
`define ACC_BIT_BG      1
`define ACC_BIT_FG      0
`define ACC_FG_BASE     16
`define ACC_BG_PHASE    64
`endif

// ### hw/acc_pkg.sv
// types shared by the calibration control block
package acc_pkg;
  typedef enum logic [2:0] {
    ACC_HOLD, ACC_START, ACC_FG, ACC_DONE, ACC_BG
  } acc_state_t;
endpackage

// ### bench/adc_calibration_control_tb.sv
// self-checking bench for the calibration control register block
`timescale 1ns/1ps
`include "acc_consts.svh"
module adc_calibration_control_tb;
  localparam int FG_C = 2;
  logic       clk   = 1'b0;
  logic       rst_b = 1'b0;
  logic [7:0] addr  = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic       halt  = 1'b0;
  logic [7:0] rdata;
  logic       cal_rst_b, div_rst_b, fg_run, fg_os, bg_run, bg_os;
  logic       link_en, irq;
  logic [1:0] idle_core;
  logic [2:0] offset_averaging_depth, lin_avg;
  int         err_total   = 0;
  int         comparisons = 0;
  int         n;

  // device under test with a short foreground base count
  acc_top #(.FG_CYCLES(FG_C)) i_dut (
    .CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CAL_RESET_B(cal_rst_b), .DIV_RESET_B(div_rst_b),
    .FG_RUN(fg_run), .FG_OFFSET_TRIM(fg_os), .BG_RUN(bg_run),
    .BG_OFFSET_TRIM(bg_os), .IDLE_CORE(idle_core),
    .OFFSET_AVERAGING_DEPTH(offset_averaging_depth), .LINEARITY_AVERAGING_DEPTH(lin_avg),
    .SERIAL_LINK_ENABLE(link_en), .BG_HALT_REQ(halt), .IRQ(irq));

  // 20 MHz clock
  always #25 clk = ~clk;

  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // compare seen against expected
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // one-cycle read, data taken in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // wait for a foreground run and count its length in cycles
  task automatic fg_len(output int len, output logic trim);
    int k;
    len  = 0;
    trim = 1'b0;
    for (k = 0; k < 100 && fg_run !== 1'b1; k++) idle(1);
    trim = fg_os;
    for (k = 0; k < 200 && fg_run === 1'b1; k++) begin
      idle(1);
      len++;
    end
    if (len == 0 || k == 200) begin
      err_total++;
      $display("unexpected wait limit at %0t: seen %h expected %h",
               $time, len, 1);
      tally_and_finish();
    end
  endtask

  // watchdog against a hang
  initial begin
    #2000000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    logic t;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    // reset values and automatic first calibration
    chk({5'h00, offset_averaging_depth}, 8'h06);
    chk({5'h00, lin_avg}, 8'h01);
    fg_len(n, t);
    chk(n[7:0], 8'(FG_C << 1));
    idle(3);
    rd_chk(`ACC_OFF_RUN, `ACC_RST_RUN);
    rd_chk(`ACC_OFF_MODE, `ACC_RST_MODE);
    rd_chk(`ACC_OFF_CORE, `ACC_RST_CORE);
    rd_chk(`ACC_OFF_AVG, `ACC_RST_AVG);
    rd_chk(`ACC_OFF_STATUS, 8'h03);
    chk({7'h00, bg_run}, 8'h00);
    rd_chk(8'h00, 8'h00);
    $display("test reset values done");
    // link on, then off before holding calibration
    wr_reg(`ACC_OFF_LINK, 8'h01);
    idle(3);
    chk({7'h00, link_en}, 8'h01);
    wr_reg(`ACC_OFF_LINK, 8'h00);
    wr_reg(`ACC_OFF_RUN, 8'h00);
    idle(3);
    chk({6'h00, cal_rst_b, div_rst_b}, 8'h00);
    // new settings must not show until the run bit rises again
    wr_reg(`ACC_OFF_MODE, 8'h0E);
    wr_reg(`ACC_OFF_CORE, 8'hFC);
    wr_reg(`ACC_OFF_AVG, 8'hF3);
    idle(3);
    chk({1'b0, offset_averaging_depth, 2'h0, idle_core}, 8'h62);
    rd_chk(`ACC_OFF_CORE, 8'h00);
    rd_chk(`ACC_OFF_AVG, 8'h73);
    wr_reg(`ACC_OFF_RUN, 8'h01);
    idle(6);
    chk({6'h00, cal_rst_b, div_rst_b}, 8'h03);
    chk({1'b0, offset_averaging_depth, 1'b0, lin_avg}, 8'h73);
    chk({6'h00, idle_core}, 8'h00);
    chk({5'h00, fg_run, bg_run, bg_os}, 8'h03);
    rd_chk(`ACC_OFF_STATUS, 8'h01);
    $display("test background mode done");
    // halt request, interrupt mask and clear
    chk({7'h00, irq}, 8'h01);
    wr_reg(`ACC_OFF_IRQ_MSK, 8'h03);
    wr_reg(`ACC_OFF_IRQ_ST, 8'h03);
    idle(2);
    chk({7'h00, irq}, 8'h00);
    @(posedge clk);
    halt <= 1'b1;
    idle(6);
    rd_chk(`ACC_OFF_STATUS, 8'h03);
    chk({6'h00, bg_run, bg_os}, 8'h00);
    rd_chk(`ACC_OFF_IRQ_ST, 8'h02);
    chk({7'h00, irq}, 8'h00);
    wr_reg(`ACC_OFF_IRQ_MSK, 8'h00);
    idle(2);
    chk({7'h00, irq}, 8'h01);
    wr_reg(`ACC_OFF_IRQ_ST, 8'h02);
    idle(2);
    chk({7'h00, irq}, 8'h00);
    @(posedge clk);
    halt <= 1'b0;
    idle(6);
    rd_chk(`ACC_OFF_STATUS, 8'h01);
    chk({7'h00, bg_run}, 8'h01);
    $display("test halt and interrupt done");
    // foreground with offset trim and deeper linearity averaging
    wr_reg(`ACC_OFF_RUN, 8'h00);
    wr_reg(`ACC_OFF_MODE, 8'h05);
    wr_reg(`ACC_OFF_RUN, 8'h01);
    fg_len(n, t);
    chk({7'h00, t}, 8'h01);
    chk(n[7:0], 8'(FG_C << 3));
    chk({7'h00, bg_run}, 8'h00);
    idle(2);
    rd_chk(`ACC_OFF_STATUS, 8'h03);
    $display("test foreground trim done");
    tally_and_finish();
  end
endmodule
